//--- rtl/emb_bus_ctl.sv
// External memory bus controller: registers, pin ownership and bus cycles.
// Assumes a core raising one-cycle access requests on clk_sys and an AHB-Lite master.
// Operation
// R1 - Internal-only mode ignores control register writes.
// R2 - Release bit clear: bus owns pins.
// R3 - Release bit set: ports, bus on access.
// R4 - Release bit resets to zero.
// R5 - Wait field code maps to 3..0 cycles.
// R6 - Waits only when enabled, after cycle.
// R7 - Word write pairs bytes, odd strobes.
// R8 - Byte select: latch both lanes, enables.
// R9 - Byte write: latch both lanes, high/low.
// R10 - Write style ignored in 8-bit width.
// R11 - Fixed setting selects 16 or 8-bit.
// R12 - Fixed field selects address width, mode.
// R13 - Unused high lines stay plain I/O.
// R14 - Address width should cover data width.
// R15 - 8-bit: low lines multiplexed, rest address.
// R16 - Optional offset by internal memory size.
// R17 - Byte address line gives 21-bit reach.
// R18 - Per-port pull-ups, clear enables them.
// R19 - Reset disables all bus pull-ups.
// R20 - Unimplemented control bits read zero.
// R21 - Idle bus: data tristate, strobes inactive.
// R22 - Release from external code deferred.
// R23 - Bus beats all sharing peripherals.
// R24 - Delay disabled means zero waits.
//
// The AHB-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module emb_bus_ctl
  import emb_pkg::*;
#(
  parameter logic [20:0] INT_MEM_BYTES = 21'h008000,
  parameter int CYC_CLKS = 4
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic resetn,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Nonvolatile settings, held stable from reset.
  input wire logic dataWidthSelect,
  input wire logic [1:0] programModeAddressWidth,
  input wire logic delayInsertEnable,
  input wire logic addressOffsetEnable,
  // Core access port.
  input wire logic execInternal,
  input wire logic accReq,
  input wire logic accTable,
  input wire logic accWrite,
  input wire logic [20:0] tablePointer,
  input wire logic [7:0] tableDataLatch,
  output logic accBusy,
  output logic accDone,
  output logic [15:0] accRdData,
  // Bus pins.
  input wire logic [15:0] adIn,
  output logic [15:0] adOut,
  output logic [15:0] adOe,
  output logic [3:0] addrHighOut,
  output logic addrHighOe,
  output logic addrLatchEnable,
  output logic outputEnableN,
  output logic chipEnableN,
  output logic writeHighStrobeN,
  output logic writeLowStrobeN,
  output logic byteAddressLsb,
  output logic upperByteEnableN,
  output logic lowerByteEnableN,
  // Pin ownership, high means the I/O port owns the pin.
  output logic portDOwnIo,
  output logic [7:0] portEOwnIo,
  output logic [3:0] portHOwnIo,
  output logic portJOwnIo,
  // Weak pull-up enables, high means enabled.
  output logic weakPullEnD,
  output logic weakPullEnE,
  output logic weakPullEnJ
);

  // The data phase must hold at least two clocks after the address clock.
  initial begin
    if (CYC_CLKS < 3 || CYC_CLKS > 16) begin
      $error("CYC_CLKS must lie between 3 and 16");
    end
  end

  // Register state.
  logic [7:0] ctrl_q;
  logic [7:0] pull_q;
  logic relEff_q;
  // Captured nonvolatile settings; mode resets to internal-only so the bus is quiet.
  logic cfgDone_q;
  logic cfgWide_q;
  logic [1:0] cfgMode_q;
  logic cfgWaitEn_q;
  logic cfgShift_q;
  // AHB-Lite bookkeeping.
  logic wrPend_q;
  logic rdPend_q;
  logic [7:0] regAddr_q;
  logic hreadyout_q;
  logic [31:0] hrdata_q;
  // Bus cycle state.
  emb_state_t state_q;
  logic [6:0] dataCnt_q;
  logic isWrite_q;
  logic [7:0] evenByte_q;
  logic [15:0] adInS1_q;
  logic [15:0] adInS2_q;
  logic [15:0] adInS3_q;
  logic [15:0] adInF_q;

  // Derived decode of the settings.
  logic extMode;
  logic addr16Plus;
  logic addr20;
  logic [15:0] usedMask;
  logic [1:0] waitCycles;
  logic take;
  logic lastData;
  logic ownBus;
  logic addrTaken;
  logic [20:0] busAddr;

  // R12 - width decode
  assign extMode = cfgMode_q != EMB_MODE_MCU;
  assign addr16Plus = cfgMode_q != EMB_MODE_A12;
  assign addr20 = cfgMode_q == EMB_MODE_A20;
  // R13 - unused lines freed
  assign usedMask = {{4{addr16Plus}}, 12'hfff};
  // R5 - code to cycles
  // R24 - disabled means none
  assign waitCycles = cfgWaitEn_q ? (EMB_WAIT_MAX - ctrl_q[EMB_CTRL_WAIT_HI:EMB_CTRL_WAIT_LO])
                                  : 2'h0;
  assign take = accReq && extMode && (state_q == EMB_ST_IDLE);
  assign lastData = (state_q == EMB_ST_DATA) && (dataCnt_q == 7'h00);
  // R2 - bus holds pins
  // R3 - access takes pins
  assign ownBus = extMode && (!relEff_q || take || (state_q != EMB_ST_IDLE && !lastData));
  // R16 - offset address
  assign busAddr = cfgShift_q ? (tablePointer - INT_MEM_BYTES) : tablePointer;
  assign addrTaken = hsel && htrans[1] && hready;

  // Settings are caught once, on the first edge out of reset.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cfgDone_q <= 1'b0;
      cfgWide_q <= 1'b1;
      cfgMode_q <= EMB_MODE_MCU;
      cfgWaitEn_q <= 1'b0;
      cfgShift_q <= 1'b0;
    end else if (!cfgDone_q) begin
      // R11 - width fixed here
      cfgDone_q <= 1'b1;
      cfgWide_q <= dataWidthSelect;
      cfgMode_q <= programModeAddressWidth;
      cfgWaitEn_q <= delayInsertEnable;
      cfgShift_q <= addressOffsetEnable;
    end
  end

  // Address phase capture; reads get one wait cycle so hrdata comes from a flop.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      wrPend_q <= 1'b0;
      rdPend_q <= 1'b0;
      regAddr_q <= 8'h00;
      hreadyout_q <= 1'b1;
    end else begin
      wrPend_q <= addrTaken && hwrite;
      rdPend_q <= addrTaken && !hwrite;
      hreadyout_q <= !(addrTaken && !hwrite);
      if (addrTaken) begin
        regAddr_q <= haddr[7:0];
      end
    end
  end

  // Read data mux; unmapped offsets read as zero.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      hrdata_q <= 32'h00000000;
    end else if (rdPend_q) begin
      // R20 - reserved bits zero
      unique case (regAddr_q)
        EMB_OFS_CTRL: hrdata_q <= {24'h000000, ctrl_q & EMB_CTRL_WMASK};
        EMB_OFS_PULL: hrdata_q <= {24'h000000, pull_q & EMB_PULL_WMASK};
        EMB_OFS_STAT: begin
          hrdata_q <= 32'h00000000;
          hrdata_q[EMB_ST_WIDE] <= cfgWide_q;
          hrdata_q[EMB_ST_MODE_LO +: 2] <= cfgMode_q;
          hrdata_q[EMB_ST_WAITEN] <= cfgWaitEn_q;
          hrdata_q[EMB_ST_SHIFT] <= cfgShift_q;
          hrdata_q[EMB_ST_REL] <= relEff_q;
          hrdata_q[EMB_ST_BUSY] <= state_q != EMB_ST_IDLE;
        end
        default: hrdata_q <= 32'h00000000;
      endcase
    end
  end

  // Bus control register; in internal-only mode it is frozen at reset value.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      // R4 - release bit clear
      ctrl_q <= EMB_CTRL_RESET;
    end else if (wrPend_q && regAddr_q == EMB_OFS_CTRL && extMode) begin
      // R1 - writes need bus mode
      ctrl_q <= hwdata[7:0] & EMB_CTRL_WMASK;
    end
  end

  // Pull-up host register, reset to all pull-ups off.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      // R19 - pull-ups off
      pull_q <= EMB_PULL_RESET;
    end else if (wrPend_q && regAddr_q == EMB_OFS_PULL) begin
      pull_q <= hwdata[7:0] & EMB_PULL_WMASK;
    end
  end

  // A set release lands only while running inside, else pins vanish under fetches.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      relEff_q <= 1'b0;
    end else if (!ctrl_q[EMB_CTRL_REL]) begin
      relEff_q <= 1'b0;
    end else if (execInternal) begin
      // R22 - deferred release
      relEff_q <= 1'b1;
    end
  end

  // Read data passes three flops; a value counts once stages two and three agree.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      adInS1_q <= 16'h0000;
      adInS2_q <= 16'h0000;
      adInS3_q <= 16'h0000;
      adInF_q <= 16'h0000;
    end else begin
      adInS1_q <= adIn;
      adInS2_q <= adInS1_q;
      adInS3_q <= adInS2_q;
      if (adInS2_q == adInS3_q) begin
        adInF_q <= adInS3_q;
      end
    end
  end

  // Pin ownership and pull-up outputs, one flop each.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      portDOwnIo <= 1'b1;
      portEOwnIo <= 8'hff;
      portHOwnIo <= 4'hf;
      portJOwnIo <= 1'b1;
      weakPullEnD <= 1'b0;
      weakPullEnE <= 1'b0;
      weakPullEnJ <= 1'b0;
    end else begin
      // R23 - bus wins pins
      // R15 - line assignment
      portDOwnIo <= !ownBus;
      portEOwnIo <= ~({{4{ownBus && addr16Plus}}, {4{ownBus}}});
      portHOwnIo <= {4{!(ownBus && addr20)}};
      portJOwnIo <= !ownBus;
      // R18 - clear enables pull-ups
      weakPullEnD <= !pull_q[EMB_PULL_D];
      weakPullEnE <= !pull_q[EMB_PULL_E];
      weakPullEnJ <= !pull_q[EMB_PULL_J];
    end
  end

  // Bus cycle: an address clock, then a data phase of the rest of the cycle plus waits.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state_q <= EMB_ST_IDLE;
      dataCnt_q <= 7'h00;
      isWrite_q <= 1'b0;
      evenByte_q <= 8'h00;
      accBusy <= 1'b0;
      accDone <= 1'b0;
      accRdData <= 16'h0000;
      adOut <= 16'h0000;
      adOe <= 16'h0000;
      addrHighOut <= 4'h0;
      addrHighOe <= 1'b0;
      addrLatchEnable <= 1'b0;
      outputEnableN <= 1'b1;
      chipEnableN <= 1'b1;
      writeHighStrobeN <= 1'b1;
      writeLowStrobeN <= 1'b1;
      byteAddressLsb <= 1'b0;
      upperByteEnableN <= 1'b1;
      lowerByteEnableN <= 1'b1;
    end else begin
      accDone <= 1'b0;
      unique case (state_q)
        EMB_ST_IDLE: begin
          if (take) begin
            state_q <= EMB_ST_ADDR;
            accBusy <= 1'b1;
            isWrite_q <= accWrite && accTable;
            // R17 - byte line is lsb
            adOut <= busAddr[16:1];
            adOe <= usedMask;
            addrHighOut <= busAddr[20:17];
            addrHighOe <= addr20;
            byteAddressLsb <= busAddr[0];
            addrLatchEnable <= 1'b1;
            chipEnableN <= 1'b0;
            // R6 - waits follow the cycle
            // Reads hold two more clocks so the pin synchroniser settles.
            dataCnt_q <= 7'(CYC_CLKS - 2) + 7'(int'(accTable ? waitCycles : 2'h0) * CYC_CLKS)
                         + 7'((accWrite && accTable) ? 0 : 2);
          end
        end
        EMB_ST_ADDR: begin
          state_q <= EMB_ST_DATA;
          addrLatchEnable <= 1'b0;
          if (!isWrite_q) begin
            // Reads: data lanes float, address-only lines keep the address.
            outputEnableN <= 1'b0;
            upperByteEnableN <= 1'b0;
            lowerByteEnableN <= 1'b0;
            adOe <= cfgWide_q ? 16'h0000 : {usedMask[15:8], 8'h00};
          end else if (!cfgWide_q) begin
            // R10 - style ignored at 8 bits
            adOut <= {adOut[15:8], tableDataLatch};
            writeLowStrobeN <= 1'b0;
          end else if (ctrl_q[EMB_CTRL_WM_HI]) begin
            // R7 - word write pairing
            if (byteAddressLsb) begin
              adOut <= {tableDataLatch, evenByte_q};
              writeHighStrobeN <= 1'b0;
              upperByteEnableN <= 1'b0;
              lowerByteEnableN <= 1'b0;
            end else begin
              evenByte_q <= tableDataLatch;
              adOe <= 16'h0000;
            end
          end else if (ctrl_q[EMB_CTRL_WM_HI:EMB_CTRL_WM_LO] == EMB_WM_BYTESEL) begin
            // R8 - byte select lanes
            adOut <= {tableDataLatch, tableDataLatch};
            writeHighStrobeN <= 1'b0;
            upperByteEnableN <= !byteAddressLsb;
            lowerByteEnableN <= byteAddressLsb;
          end else begin
            // R9 - byte write strobes
            adOut <= {tableDataLatch, tableDataLatch};
            writeHighStrobeN <= !byteAddressLsb;
            writeLowStrobeN <= byteAddressLsb;
          end
        end
        EMB_ST_DATA: begin
          if (dataCnt_q != 7'h00) begin
            dataCnt_q <= dataCnt_q - 7'h01;
          end else begin
            // R21 - idle pin levels
            state_q <= EMB_ST_IDLE;
            accBusy <= 1'b0;
            accDone <= 1'b1;
            if (!isWrite_q) begin
              accRdData <= adInF_q;
            end
            adOe <= 16'h0000;
            addrHighOe <= 1'b0;
            outputEnableN <= 1'b1;
            chipEnableN <= 1'b1;
            writeHighStrobeN <= 1'b1;
            writeLowStrobeN <= 1'b1;
            upperByteEnableN <= 1'b1;
            lowerByteEnableN <= 1'b1;
            byteAddressLsb <= 1'b0;
          end
        end
      endcase
    end
  end

  // Bus port outputs.
  assign hreadyout = hreadyout_q;
  assign hrdata = hrdata_q;
  assign hresp = 1'b0;

  // Checks next to the logic they guard.
  a_mcu_locks_ctrl: assert property (@(posedge clk_sys) disable iff (!resetn) // R1
    (wrPend_q && !extMode) |=> (ctrl_q == $past(ctrl_q)))
    else $error("ctrl written in internal mode");
  a_bus_holds_pins: assert property (@(posedge clk_sys) disable iff (!resetn) // R2
    (extMode && !relEff_q) |=> !portDOwnIo && !portJOwnIo)
    else $error("port owns bus pin");
  a_access_takes_pins: assert property (@(posedge clk_sys) disable iff (!resetn) // R3
    (state_q == EMB_ST_DATA) |-> !portDOwnIo)
    else $error("port owns pin in access");
  a_reset_ctrl_zero: assert property (@(posedge clk_sys) // R4
    $rose(resetn) |-> ctrl_q == EMB_CTRL_RESET && !relEff_q)
    else $error("ctrl not reset");
  a_wait_length: assert property (@(posedge clk_sys) disable iff (!resetn) // R5
    (take && accTable && accWrite && cfgWaitEn_q && waitCycles == 2'h3)
      |=> ##1 (state_q == EMB_ST_DATA) [*8] ##7 (state_q == EMB_ST_DATA) ##1 accDone)
    else $error("wait length wrong");
  a_no_wait_disabled: assert property (@(posedge clk_sys) disable iff (!resetn) // R24
    (take && !cfgWaitEn_q) |=> (state_q == EMB_ST_ADDR)
      ##1 (dataCnt_q == 7'(CYC_CLKS - (isWrite_q ? 2 : 0))))
    else $error("wait while disabled");
  a_word_even_quiet: assert property (@(posedge clk_sys) disable iff (!resetn) // R7
    (state_q == EMB_ST_DATA && isWrite_q && cfgWide_q && ctrl_q[1] && !byteAddressLsb)
      |-> writeHighStrobeN && writeLowStrobeN && adOe == 16'h0000)
    else $error("even word write drove the bus");
  a_bytesel_strobe: assert property (@(posedge clk_sys) disable iff (!resetn) // R8
    (state_q == EMB_ST_DATA && isWrite_q && cfgWide_q && ctrl_q[1:0] == EMB_WM_BYTESEL)
      |-> !writeHighStrobeN && (upperByteEnableN != lowerByteEnableN))
    else $error("byte select strobes wrong");
  a_bytewr_strobe: assert property (@(posedge clk_sys) disable iff (!resetn) // R9
    (state_q == EMB_ST_DATA && isWrite_q && cfgWide_q && ctrl_q[1:0] == EMB_WM_BYTEWR)
      |-> (writeHighStrobeN != writeLowStrobeN) && adOut[15:8] == adOut[7:0])
    else $error("byte write strobes wrong");
  a_idle_quiet: assert property (@(posedge clk_sys) disable iff (!resetn) // R21
    (state_q == EMB_ST_IDLE) |-> adOe == 16'h0000 && chipEnableN && outputEnableN
      && writeHighStrobeN && writeLowStrobeN && upperByteEnableN && lowerByteEnableN
      && !addrLatchEnable && !byteAddressLsb)
    else $error("idle pins not at rest");
  a_pullups_reset: assert property (@(posedge clk_sys) // R19
    $rose(resetn) |-> !weakPullEnD && !weakPullEnE && !weakPullEnJ)
    else $error("pull-ups on after reset");

  // Main scenarios.
  c_table_write: cover property (@(posedge clk_sys) disable iff (!resetn)
    take && accWrite && accTable);
  c_read_done: cover property (@(posedge clk_sys) disable iff (!resetn)
    accDone && !isWrite_q);
  c_release_lands: cover property (@(posedge clk_sys) disable iff (!resetn)
    $rose(relEff_q));

endmodule

`default_nettype wire

//--- rtl/emb_pkg.sv
// Shared constants for the external memory bus controller.
// Assumes a 32-bit AHB-Lite register port with word-aligned registers.
package emb_pkg;

  // Register byte offsets on the bus.
  localparam logic [7:0] EMB_OFS_CTRL = 8'h00;
  localparam logic [7:0] EMB_OFS_PULL = 8'h04;
  localparam logic [7:0] EMB_OFS_STAT = 8'h08;

  // Bus control register: reset value, writable bits and field positions.
  localparam logic [7:0] EMB_CTRL_RESET = 8'h00;
  localparam logic [7:0] EMB_CTRL_WMASK = 8'hb3;
  localparam int EMB_CTRL_REL = 7;
  localparam int EMB_CTRL_WAIT_HI = 5;
  localparam int EMB_CTRL_WAIT_LO = 4;
  localparam int EMB_CTRL_WM_HI = 1;
  localparam int EMB_CTRL_WM_LO = 0;

  // Pull-up host register: only the top three bits exist, set means disabled.
  localparam logic [7:0] EMB_PULL_RESET = 8'he0;
  localparam logic [7:0] EMB_PULL_WMASK = 8'he0;
  localparam int EMB_PULL_D = 7;
  localparam int EMB_PULL_E = 6;
  localparam int EMB_PULL_J = 5;

  // Status register bit positions.
  localparam int EMB_ST_WIDE = 0;
  localparam int EMB_ST_MODE_LO = 1;
  localparam int EMB_ST_WAITEN = 3;
  localparam int EMB_ST_SHIFT = 4;
  localparam int EMB_ST_REL = 5;
  localparam int EMB_ST_BUSY = 6;

  // Program mode and address width encodings.
  localparam logic [1:0] EMB_MODE_A20 = 2'h0;
  localparam logic [1:0] EMB_MODE_A16 = 2'h1;
  localparam logic [1:0] EMB_MODE_A12 = 2'h2;
  localparam logic [1:0] EMB_MODE_MCU = 2'h3;

  // Write style encodings; the top bit alone selects word write.
  localparam logic [1:0] EMB_WM_BYTESEL = 2'h1;
  localparam logic [1:0] EMB_WM_BYTEWR = 2'h0;

  // Largest table wait in instruction cycles (field code 00).
  localparam logic [1:0] EMB_WAIT_MAX = 2'h3;

  // Bus cycle states.
  typedef enum logic [2:0] {
    EMB_ST_IDLE = 3'b001,
    EMB_ST_ADDR = 3'b010,
    EMB_ST_DATA = 3'b100
  } emb_state_t;

endpackage

//--- sim/emb_ext_mem.sv
// Behavioural external word memory on the multiplexed bus of the controller.
// Assumes the controller drives registered pins on clk_sys; it resolves the shared lines.
`timescale 1ns/1ps
`default_nettype none

module emb_ext_mem (
  // Clock.
  input wire logic clk_sys,
  // Pins driven by the controller.
  input wire logic [15:0] adOut,
  input wire logic [15:0] adOe,
  input wire logic addrLatchEnable,
  input wire logic outputEnableN,
  input wire logic chipEnableN,
  input wire logic weakPullEnD,
  input wire logic weakPullEnE,
  // Resolved line levels.
  output logic [15:0] adIn
);
  logic [15:0] latAddr = 16'h0000; // Address caught while the latch strobe is high.
  logic [15:0] lastLevel = 16'h0000; // Last resolved level.
  logic memDrive; // Memory drives when selected and enabled.

  // The address is caught on the edge that sees the latch strobe.
  always @(posedge clk_sys) begin
    if (addrLatchEnable) begin
      latAddr <= adOut;
    end
    lastLevel <= adIn;
  end

  assign memDrive = !outputEnableN && !chipEnableN;

  // An undriven line without pull-up shows the inverse of its last level.
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (adOe[i]) begin
        adIn[i] = adOut[i];
      end else if (memDrive) begin
        adIn[i] = latAddr[i] ^ 1'((16'h5a3c >> i) & 16'h0001);
      end else if ((i < 8) ? weakPullEnD : weakPullEnE) begin
        adIn[i] = 1'b1;
      end else begin
        adIn[i] = ~lastLevel[i];
      end
    end
  end
endmodule
`default_nettype wire

//--- sim/external_memory_bus_control_bench.sv
// Self-checking bench for the external memory bus controller.
// Assumes one AHB-Lite master (this bench), one core port and the memory model.
`timescale 1ns/1ps
`default_nettype none

module external_memory_bus_control_bench;
  import emb_pkg::*;
  localparam logic [20:0] IMB = 21'h008000; // Internal memory size.
  logic clk_sys = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0, pmaw = EMB_MODE_A16;
  logic dws = 1'b1, die = 1'b1, aoe = 1'b0, execInternal = 1'b0;
  logic accReq = 1'b0, accTable = 1'b0, accWrite = 1'b0, accBusy, accDone;
  logic [20:0] tablePointer = 21'h0;
  logic [7:0] tableDataLatch = 8'h00, portEOwnIo;
  logic [15:0] accRdData, adIn, adOut, adOe, wrData, aleAddr;
  logic [3:0] addrHighOut, portHOwnIo, lows;
  logic addrHighOe, ale, oeN, ceN, wrhN, wrlN, ba, ubN, lbN, portDOwnIo, portJOwnIo;
  logic weakPullEnD, weakPullEnE, weakPullEnJ, aleBa, ownDuring;
  logic [13:0] own;
  logic [2:0] pulls;
  int num_errors = 0, n_tests = 0, nCyc, cycles = 0;

  always #12.5 clk_sys = ~clk_sys;
  assign own = {portDOwnIo, portEOwnIo, portHOwnIo, portJOwnIo};
  assign pulls = {weakPullEnD, weakPullEnE, weakPullEnJ};

  emb_bus_ctl #(.INT_MEM_BYTES(IMB), .CYC_CLKS(4)) u_dut (.clk_sys(clk_sys),
    .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .dataWidthSelect(dws), .programModeAddressWidth(pmaw),
    .delayInsertEnable(die), .addressOffsetEnable(aoe), .execInternal(execInternal),
    .accReq(accReq), .accTable(accTable), .accWrite(accWrite), .tablePointer(tablePointer),
    .tableDataLatch(tableDataLatch), .accBusy(accBusy), .accDone(accDone),
    .accRdData(accRdData), .adIn(adIn), .adOut(adOut), .adOe(adOe),
    .addrHighOut(addrHighOut), .addrHighOe(addrHighOe), .addrLatchEnable(ale),
    .outputEnableN(oeN), .chipEnableN(ceN), .writeHighStrobeN(wrhN), .writeLowStrobeN(wrlN),
    .byteAddressLsb(ba), .upperByteEnableN(ubN), .lowerByteEnableN(lbN),
    .portDOwnIo(portDOwnIo), .portEOwnIo(portEOwnIo), .portHOwnIo(portHOwnIo),
    .portJOwnIo(portJOwnIo), .weakPullEnD(weakPullEnD), .weakPullEnE(weakPullEnE),
    .weakPullEnJ(weakPullEnJ));

  emb_ext_mem u_mem (.clk_sys(clk_sys), .adOut(adOut), .adOe(adOe), .addrLatchEnable(ale),
    .outputEnableN(oeN), .chipEnableN(ceN), .weakPullEnD(weakPullEnD),
    .weakPullEnE(weakPullEnE), .adIn(adIn));

  // Counts every comparison and reports a mismatch at once.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Ceiling on the run length; a hang counts as a mismatch.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      give_verdict();
    end
  end

  // Applies fixed settings and holds reset low for four edges.
  task automatic rst(input logic w, input logic [1:0] m, input logic we, input logic sh);
    dws <= w;
    pmaw <= m;
    die <= we;
    aoe <= sh;
    resetn <= 1'b0;
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask

  // One AHB-Lite word transfer, each phase held until hready is seen high.
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // One core access; records strobes, latched address and ownership while it runs.
  task automatic acc(input logic t, input logic w, input logic [20:0] p, input logic [7:0] d);
    lows = 4'h0;
    accReq <= 1'b1;
    accTable <= t;
    accWrite <= w;
    tablePointer <= p;
    tableDataLatch <= d;
    @(posedge clk_sys);
    accReq <= 1'b0;
    nCyc = 0;
    do begin
      @(posedge clk_sys);
      nCyc++;
      if (ale === 1'b1) begin
        aleAddr = adOut;
        aleBa = ba;
        ownDuring = portDOwnIo;
      end
      if (wrhN === 1'b0 || wrlN === 1'b0) wrData = adOut;
      lows |= {wrhN === 1'b0, wrlN === 1'b0, ubN === 1'b0, lbN === 1'b0};
    end while (accDone !== 1'b1 && nCyc < 100);
  endtask

  // A table write judged by its active-low strobes and the lanes it drives.
  task automatic wr(input logic [20:0] p, input logic [7:0] d, input logic [3:0] mask,
                    input logic [3:0] exp, input logic [15:0] expData);
    acc(1'b1, 1'b1, p, d);
    chk(lows & mask, exp, "strobes");
    if (exp != 4'h0) chk(wrData, expData, "lanes");
  endtask

  // Reset state of registers, pins, ownership and pull-ups.
  task automatic t_reset();
    rst(1'b1, EMB_MODE_A16, 1'b1, 1'b0);
    ahb(1'b0, EMB_OFS_CTRL, 32'h0); chk(rd, 32'h0, "ctrl reset");
    ahb(1'b0, EMB_OFS_PULL, 32'h0); chk(rd, 32'he0, "pull reset");
    ahb(1'b0, 8'h0c, 32'h0); chk(rd, 32'h0, "unmapped read");
    chk({adOe, ceN, oeN, wrhN, wrlN, ubN, lbN, ale, ba}, {16'h0, 6'h3f, 2'h0}, "rest");
    chk(own, {1'h0, 8'h00, 4'hf, 1'h0}, "own");
    chk(pulls, 3'h0, "pulls off");
    $display("test reset done");
  endtask

  // Unimplemented bits and per-port pull-up control.
  task automatic t_regs();
    ahb(1'b1, EMB_OFS_CTRL, 32'hff);
    ahb(1'b0, EMB_OFS_CTRL, 32'h0); chk(rd, 32'hb3, "ctrl mask");
    ahb(1'b1, EMB_OFS_PULL, 32'h00);
    repeat (2) @(posedge clk_sys);
    chk(pulls, 3'h7, "pulls on");
    ahb(1'b1, EMB_OFS_PULL, 32'h40);
    repeat (2) @(posedge clk_sys);
    chk(pulls, 3'h5, "port E off");
    $display("test regs done");
  endtask

  // Every wait code on table reads, then a fetch that never waits.
  task automatic t_waits();
    for (int c = 0; c < 4; c++) begin
      ahb(1'b1, EMB_OFS_CTRL, 32'(c) << 4);
      acc(1'b1, 1'b0, 21'h000124, 8'h00);
      chk(nCyc, 4 * (4 - c) + 3, "wait length");
      chk(accRdData, 16'h0092 ^ 16'h5a3c, "read data");
    end
    acc(1'b0, 1'b0, 21'h000125, 8'h00);
    chk(nCyc, 7, "fetch length");
    chk({aleAddr, aleBa}, {16'h0092, 1'h1}, "addr bit");
    $display("test waits done");
  endtask

  // All three write styles, odd and even bytes.
  task automatic t_styles();
    ahb(1'b1, EMB_OFS_CTRL, 32'h0);
    wr(21'h000203, 8'ha5, 4'hc, 4'h8, 16'ha5a5);
    wr(21'h000202, 8'h5a, 4'hc, 4'h4, 16'h5a5a);
    ahb(1'b1, EMB_OFS_CTRL, 32'h1);
    wr(21'h000203, 8'hc3, 4'hf, 4'ha, 16'hc3c3);
    wr(21'h000202, 8'h3c, 4'hf, 4'h9, 16'h3c3c);
    ahb(1'b1, EMB_OFS_CTRL, 32'h2);
    wr(21'h000204, 8'h11, 4'hf, 4'h0, 16'h0000);
    wr(21'h000205, 8'h22, 4'hf, 4'hb, 16'h2211);
    $display("test styles done");
  endtask

  // Release bit: deferred while running outside, ports when inside, bus on access.
  task automatic t_release();
    ahb(1'b1, EMB_OFS_CTRL, 32'h80);
    repeat (2) @(posedge clk_sys);
    ahb(1'b0, EMB_OFS_STAT, 32'h0);
    chk({rd[EMB_ST_REL], portDOwnIo}, 2'h0, "release deferred");
    execInternal <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk(own, 14'h3fff, "ports own");
    acc(1'b1, 1'b0, 21'h000040, 8'h00);
    chk(ownDuring, 1'b0, "bus takes pins");
    ahb(1'b1, EMB_OFS_CTRL, 32'h00);
    repeat (3) @(posedge clk_sys);
    chk({portDOwnIo, portJOwnIo}, 2'h0, "bus owns again");
    execInternal <= 1'b0;
    $display("test release done");
  endtask

  // No waits when disabled; offset address in 20-bit width.
  task automatic t_offset();
    rst(1'b1, EMB_MODE_A20, 1'b0, 1'b1);
    chk(own, 14'h0, "a20 own");
    acc(1'b1, 1'b0, IMB + 21'h000006, 8'h00);
    chk(nCyc, 7, "waits disabled");
    chk({aleAddr, aleBa}, {16'h0003, 1'h0}, "offset");
    $display("test offset done");
  endtask

  // Eight-bit data with 12-bit addressing, wide enough for it.
  task automatic t_narrow();
    rst(1'b0, EMB_MODE_A12, 1'b1, 1'b0);
    chk(own, {1'h0, 8'hf0, 4'hf, 1'h0}, "own");
    ahb(1'b1, EMB_OFS_CTRL, 32'h32);
    wr(21'h000011, 8'h66, 4'hc, 4'h4, 16'h0066);
    $display("test narrow done");
  endtask

  // Internal-only mode: control writes dropped, ports keep every pin.
  task automatic t_internal();
    rst(1'b1, EMB_MODE_MCU, 1'b1, 1'b0);
    ahb(1'b1, EMB_OFS_CTRL, 32'hb3);
    ahb(1'b0, EMB_OFS_CTRL, 32'h0); chk(rd, 32'h0, "ctrl locked");
    chk(own, 14'h3fff, "all ports");
    $display("test internal done");
  endtask

  // Main sequence.
  initial begin
    t_reset();
    t_regs();
    t_waits();
    t_styles();
    t_release();
    t_offset();
    t_narrow();
    t_internal();
    give_verdict();
  end
endmodule
`default_nettype wire
